/* File: design/expander_link_if.sv */
// Two-wire link between the expander device and its bus master
`timescale 1ns/1ns
interface expander_link_if;

    // ------------------------------------------------------------------
    // Open-drain drivers of each party and the resolved wire levels
    // ------------------------------------------------------------------
    logic m_scl_out;
    logic m_scl_oe;
    logic m_sda_out;
    logic m_sda_oe;
    logic d_sda_out;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // Wired-AND with pull-ups: any enabled low driver wins
    assign scl = !(m_scl_oe && !m_scl_out);
    assign sda = !((m_sda_oe && !m_sda_out) || (d_sda_oe && !d_sda_out));

    modport master (
        output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe,
        input scl, sda
    );

    modport dev (
        output d_sda_out, d_sda_oe,
        input scl, sda
    );

endinterface : expander_link_if

/* File: design/expander_pkg.sv */
// Shared constants, timing counts and state encodings for the port expander link
package expander_pkg;

    // ------------------------------------------------------------------
    // Byte framing on the serial link
    // ------------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] ACK_SLOT = 4'h8; // Bit index of the acknowledge slot
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;

    // ------------------------------------------------------------------
    // Device identity and reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] DEF_SLAVE_ADDR = 7'h20; // Arbitrary default address
    localparam logic [15:0] PORT_RESET = 16'hffff; // All pins weakly high
    localparam int OCTAL_BITS = 8;

    // ------------------------------------------------------------------
    // Timing: fastest serial clock and host quarter-bit count
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 10;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
    // Least quarter period, rounded up so the clock never exceeds its maximum
    localparam int QUARTER_CYC = (SCL_PERIOD_NS + 4 * MCLK_PERIOD_NS - 1) / (4 * MCLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_ADDR = 3'h1,
        D_ADDR_ACK = 3'h2,
        D_WR = 3'h3,
        D_WR_ACK = 3'h4,
        D_RD = 3'h5,
        D_RD_ACK = 3'h6,
        D_SKIP = 3'h7
    } dev_state_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_START = 2'h1,
        H_BITS = 2'h2,
        H_STOP = 2'h3
    } host_state_t;

endpackage : expander_pkg

/* File: design/port_expander_dev.sv */
// Sixteen-pin serial port expander: slave engine, port latches and change alert
//
// Operation
// - Eight data bits then one acknowledge slot
// - No limit on bytes per transaction
// - Device acknowledges every byte it receives
// - Master acknowledges all read bytes but last
// - Acknowledger holds data low while clock high
// - Master ends read by not acknowledging
// - Device releases data line after unacknowledged byte
// - Master writes input pins high
// - Read returns pin levels, outputs as written
// - Alert line signals port change without transfer
// - Tied pins always written identical values
// - Received byte latched to port at acknowledge
// - Written bytes alternate low then high octal
// - Any write refreshes snapshots, clears alerts
// - Read byte loads current pin levels
// - Read bytes alternate low then high octal
// - Low byte read clears low alerts only
// - High byte read clears high alerts only
// - Address low bit selects write or read
// - Pin edge raises alert, undone on return
// - Reset releases pins high, idles engine
`timescale 1ns/1ns
module port_expander_dev import expander_pkg::*; #(
    parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR
) (
    // Link clock and reset
    input wire logic i_link_clk,
    input wire logic i_rst,
    // Serial link
    expander_link_if.dev link,
    // Quasi-bidirectional port pins
    input wire logic [15:0] i_port_in,
    output logic [15:0] o_port_out,
    output logic [15:0] o_port_oe,
    // Change alert, active low
    output logic o_alert_n
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        dev_state_t st;
        logic scl_q;
        logic sda_q;
        logic [3:0] bits;
        logic [7:0] sh;
        logic rw;
        logic sel;
        logic ack;
        logic sda_low;
        logic [15:0] out;
        logic [15:0] ref_lvl;
        logic alert_n;
    } dev_regs_t;

    dev_regs_t s;
    dev_regs_t next_s;

    logic [1:0] line_sync;
    logic [15:0] pins;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start_seen;
    logic stop_seen;

    // ------------------------------------------------------------------
    // Synchronisers for the link wires and the pins
    // ------------------------------------------------------------------
    // Idle bus is high, so both stages reset high to avoid a false start
    port_sync #(
        .W(2),
        .RST_VAL(2'h3)
    ) u_line_sync (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_d({link.scl, link.sda}),
        .o_q(line_sync)
    );

    // Pins are external levels and may change at any time
    port_sync #(
        .W(16),
        .RST_VAL(PORT_RESET)
    ) u_pin_sync (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_d(i_port_in),
        .o_q(pins)
    );

    // Edges and bus conditions seen on the synchronised wires
    assign scl = line_sync[1];
    assign sda = line_sync[0];
    assign rise = scl && !s.scl_q;
    assign fall = !scl && s.scl_q;
    assign start_seen = scl && s.scl_q && s.sda_q && !sda;
    assign stop_seen = scl && s.scl_q && !s.sda_q && sda;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // The device only changes its data drive after it sees the clock fall,
    // so its own acknowledge can never look like a start or stop.
    always_comb begin
        next_s = s;
        next_s.scl_q = scl;
        next_s.sda_q = sda;
        unique case (s.st)
            D_IDLE, D_SKIP: begin
                next_s.sda_low = 1'b0;
            end
            D_ADDR: begin
                if (rise) begin
                    next_s.sh = {s.sh[6:0], sda};
                    next_s.bits = s.bits + 4'h1;
                end else if (fall && s.bits == ACK_SLOT) begin
                    if (s.sh[7:1] == SLAVE_ADDR) begin
                        next_s.st = D_ADDR_ACK;
                        next_s.rw = s.sh[0];
                        next_s.sda_low = 1'b1;
                    end else begin
                        next_s.st = D_SKIP;
                    end
                end
            end
            D_ADDR_ACK: begin
                if (fall) begin
                    next_s.bits = 4'h0;
                    next_s.sel = 1'b0;
                    if (s.rw == RW_WRITE) begin
                        next_s.st = D_WR;
                        next_s.sda_low = 1'b0;
                    end else begin
                        next_s.st = D_RD;
                        next_s.sh = pins[7:0];
                        next_s.sda_low = !pins[7];
                    end
                end
            end
            D_WR: begin
                if (rise) begin
                    next_s.sh = {s.sh[6:0], sda};
                    next_s.bits = s.bits + 4'h1;
                end else if (fall && s.bits == ACK_SLOT) begin
                    // Byte lands on its octal as the acknowledge slot opens
                    if (s.sel) begin
                        next_s.out[15:8] = s.sh;
                    end else begin
                        next_s.out[7:0] = s.sh;
                    end
                    next_s.ref_lvl = pins;
                    next_s.sda_low = 1'b1;
                    next_s.st = D_WR_ACK;
                end
            end
            D_WR_ACK: begin
                // Hold low through the whole high phase of the slot
                if (fall) begin
                    next_s.sda_low = 1'b0;
                    next_s.sel = !s.sel;
                    next_s.bits = 4'h0;
                    next_s.st = D_WR;
                end
            end
            D_RD: begin
                if (rise) begin
                    next_s.bits = s.bits + 4'h1;
                end else if (fall) begin
                    if (s.bits == ACK_SLOT) begin
                        next_s.sda_low = 1'b0;
                        next_s.st = D_RD_ACK;
                        // Byte has gone out: forget changes on this octal only
                        if (s.sel) begin
                            next_s.ref_lvl[15:8] = pins[15:8];
                        end else begin
                            next_s.ref_lvl[7:0] = pins[7:0];
                        end
                    end else begin
                        next_s.sh = {s.sh[6:0], 1'b0};
                        next_s.sda_low = !s.sh[6];
                    end
                end
            end
            D_RD_ACK: begin
                if (rise) begin
                    next_s.ack = !sda;
                end else if (fall) begin
                    if (s.ack) begin
                        next_s.sel = !s.sel;
                        next_s.bits = 4'h0;
                        next_s.st = D_RD;
                        // Fresh pin levels for the next octal at byte start
                        if (s.sel) begin
                            next_s.sh = pins[7:0];
                            next_s.sda_low = !pins[7];
                        end else begin
                            next_s.sh = pins[15:8];
                            next_s.sda_low = !pins[15];
                        end
                    end else begin
                        next_s.sda_low = 1'b0;
                        next_s.st = D_SKIP;
                    end
                end
            end
        endcase
        // Bus conditions override whatever byte is in flight
        if (start_seen) begin
            next_s.st = D_ADDR;
            next_s.bits = 4'h0;
            next_s.sda_low = 1'b0;
        end else if (stop_seen) begin
            next_s.st = D_IDLE;
            next_s.sda_low = 1'b0;
        end
        // Alert follows any pin that differs from its snapshot; a pin that
        // returns to its old level drops it again. A change in the very
        // cycle of a snapshot refresh is absorbed into the new snapshot.
        next_s.alert_n = (pins == next_s.ref_lvl);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_link_clk) begin
        if (i_rst) begin
            s <= '{
                st: D_IDLE,
                scl_q: 1'b1,
                sda_q: 1'b1,
                bits: 4'h0,
                sh: 8'h00,
                rw: RW_WRITE,
                sel: 1'b0,
                ack: 1'b0,
                sda_low: 1'b0,
                out: PORT_RESET,
                ref_lvl: PORT_RESET,
                alert_n: 1'b1
            };
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // A pin latched high is only weakly pulled, so outside drivers win;
    // what a read sees is therefore the wire level itself
    assign o_port_out = s.out;
    assign o_port_oe = ~s.out;
    assign o_alert_n = s.alert_n;
    assign link.d_sda_out = 1'b0;
    assign link.d_sda_oe = s.sda_low;

endmodule : port_expander_dev

/* File: design/port_expander_host.sv */
// Bus master end: generates the serial clock and moves bytes to and from the expander
`timescale 1ns/1ns
module port_expander_host import expander_pkg::*; #(
    parameter int QUARTER = QUARTER_CYC,
    parameter int LEN_W = 16
) (
    // System clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Serial link
    expander_link_if.master link,
    // Transaction request
    input wire logic i_go,
    input wire logic i_rw,
    input wire logic [6:0] i_addr,
    input wire logic [LEN_W-1:0] i_len,
    input wire logic [15:0] i_wdata,
    // Status and read data
    output logic o_busy,
    output logic [7:0] o_rbyte,
    output logic o_rbyte_valid,
    output logic o_done,
    output logic o_addr_nack
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        host_state_t st;
        logic [15:0] div;
        logic [1:0] ph;
        logic [3:0] bits;
        logic [LEN_W-1:0] idx;
        logic [LEN_W-1:0] len;
        logic [7:0] sh;
        logic [15:0] wdata;
        logic rw;
        logic in_addr;
        logic ack;
        logic scl_oe;
        logic sda_oe;
        logic [7:0] rbyte;
        logic rvalid;
        logic done;
        logic nack;
    } host_regs_t;

    host_regs_t s;
    host_regs_t next_s;
    logic sda;
    logic tick;
    logic [LEN_W-1:0] idx_n;
    logic rx_data;

    // Data wire comes back through the open-drain network
    port_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_sda_sync (
        .i_clk(i_mclk),
        .i_rst(i_rst),
        .i_d(link.sda),
        .o_q(sda)
    );

    assign tick = (s.div == 16'(QUARTER - 1));
    assign idx_n = s.idx + LEN_W'(1);
    assign rx_data = !s.in_addr && s.rw == RW_READ;

    // ------------------------------------------------------------------
    // Next-state logic: each bit is four quarter periods
    // ------------------------------------------------------------------
    // No clock stretching: the device never holds the clock low
    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.done = 1'b0;
        if (s.st != H_IDLE) begin
            next_s.div = tick ? 16'h0000 : s.div + 16'h0001;
            if (tick) begin
                next_s.ph = s.ph + 2'h1;
            end
        end
        unique case (s.st)
            H_IDLE: begin
                if (i_go) begin
                    next_s.st = H_START;
                    next_s.rw = i_rw;
                    next_s.len = i_len;
                    next_s.wdata = i_wdata;
                    next_s.sh = {i_addr, i_rw};
                    next_s.div = 16'h0000;
                    next_s.ph = 2'h0;
                    next_s.nack = 1'b0;
                end
            end
            H_START: begin
                if (tick && s.ph == 2'h0) begin
                    next_s.sda_oe = 1'b1;
                end else if (tick && s.ph == 2'h1) begin
                    next_s.scl_oe = 1'b1;
                end else if (tick && s.ph == 2'h3) begin
                    next_s.st = H_BITS;
                    next_s.bits = 4'h0;
                    next_s.idx = '0;
                    next_s.in_addr = 1'b1;
                end
            end
            H_BITS: begin
                if (tick) begin
                    unique case (s.ph)
                        2'h0: begin
                            if (s.bits != ACK_SLOT) begin
                                next_s.sda_oe = rx_data ? 1'b0 : !s.sh[7];
                            end else begin
                                // Acknowledge all read bytes but the last
                                next_s.sda_oe = rx_data && (idx_n != s.len);
                            end
                        end
                        2'h1: begin
                            next_s.scl_oe = 1'b0;
                        end
                        2'h2: begin
                            if (s.bits != ACK_SLOT) begin
                                next_s.sh = {s.sh[6:0], sda};
                            end else begin
                                next_s.ack = !sda;
                            end
                        end
                        2'h3: begin
                            next_s.scl_oe = 1'b1;
                            if (s.bits != ACK_SLOT) begin
                                next_s.bits = s.bits + 4'h1;
                            end else begin
                                next_s.bits = 4'h0;
                                next_s.sh = s.wdata[7:0];
                                if (s.in_addr) begin
                                    next_s.in_addr = 1'b0;
                                    next_s.nack = !s.ack;
                                    if (!s.ack || s.len == '0) begin
                                        next_s.st = H_STOP;
                                    end
                                end else begin
                                    next_s.rbyte = s.sh;
                                    next_s.rvalid = rx_data;
                                    next_s.idx = idx_n;
                                    // Odd byte index goes to the high octal
                                    next_s.sh = idx_n[0] ? s.wdata[15:8] : s.wdata[7:0];
                                    if (idx_n == s.len || (!rx_data && !s.ack)) begin
                                        next_s.st = H_STOP;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (tick && s.ph == 2'h0) begin
                    next_s.sda_oe = 1'b1;
                end else if (tick && s.ph == 2'h1) begin
                    next_s.scl_oe = 1'b0;
                end else if (tick && s.ph == 2'h2) begin
                    next_s.sda_oe = 1'b0;
                end else if (tick && s.ph == 2'h3) begin
                    next_s.st = H_IDLE;
                    next_s.done = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.m_scl_out = 1'b0;
    assign link.m_scl_oe = s.scl_oe;
    assign link.m_sda_out = 1'b0;
    assign link.m_sda_oe = s.sda_oe;
    assign o_busy = (s.st != H_IDLE);
    assign o_rbyte = s.rbyte;
    assign o_rbyte_valid = s.rvalid;
    assign o_done = s.done;
    assign o_addr_nack = s.nack;

endmodule : port_expander_host

/* File: design/port_sync.sv */
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ns
module port_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Asynchronous input and synchronised output
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end

endmodule : port_sync

/* File: verif/expander_link_props.sv */
// Checker for the device side of the serial link
`timescale 1ns/1ns
module expander_link_props (
    // Link clock and reset
    input wire logic i_link_clk,
    input wire logic i_rst,
    // Link wires and device drive
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_oe
);
    default clocking cb @(posedge i_link_clk); endclocking
    default disable iff (i_rst);
    // ----------------------------------------------------------------
    // Bus idle tracker
    // ----------------------------------------------------------------
    logic idle;
    logic scl_d;
    logic sda_d;
    // STOP sets idle, START clears it; wires seen unsynchronised
    always_ff @(posedge i_link_clk) begin
        scl_d <= scl;
        sda_d <= sda;
        if (i_rst) begin
            idle <= 1'b1;
        end else if (scl && scl_d && sda != sda_d) begin
            idle <= sda;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_rst_quiet;
        disable iff (1'b0) i_rst |=> !d_sda_oe;
    endproperty
    property p_oe_rise_low;
        $rose(d_sda_oe) |-> !scl;
    endproperty
    property p_oe_fall_low;
        $fell(d_sda_oe) |-> !scl;
    endproperty
    property p_oe_stable_high;
        scl && $past(scl) |-> $stable(d_sda_oe);
    endproperty
    property p_ack_hold;
        $rose(scl) && d_sda_oe |=> d_sda_oe [*6];
    endproperty
    property p_no_start;
        scl && $fell(sda) |-> !d_sda_oe;
    endproperty
    property p_idle_free;
        idle && $past(idle) |-> !d_sda_oe;
    endproperty
    property p_pull_shows;
        d_sda_oe |-> !sda;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("data pulled in reset");
    a_oe_rise_low: assert property (p_oe_rise_low) else $error("pull while clock high");
    a_oe_fall_low: assert property (p_oe_fall_low) else $error("release while clock high");
    a_oe_stable_high: assert property (p_oe_stable_high) else $error("data moved in high");
    a_ack_hold: assert property (p_ack_hold) else $error("low not held");
    a_no_start: assert property (p_no_start) else $error("device made start");
    a_idle_free: assert property (p_idle_free) else $error("pull on idle bus");
    a_pull_shows: assert property (p_pull_shows) else $error("pull not on wire");
    // Main scenarios reached
    c_ack: cover property (scl && d_sda_oe);
    c_stop: cover property ($rose(idle));
    c_release: cover property ($fell(d_sda_oe) && !idle);
endmodule : expander_link_props

/* File: verif/testbench.sv */
// Bench joining host and expander over the link
`timescale 1ns/1ns
module testbench;
    import expander_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus and observed values
    // ----------------------------------------------------------------
    logic i_mclk = 1'b1;
    logic i_link_clk = 1'b0;
    logic i_rst = 1'b1;
    logic go = 1'b0;
    logic rw = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [15:0] len = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] ext = 16'hffff; // External drive, 1 also means pulled up
    logic [15:0] port_out;
    logic [15:0] port_oe;
    logic [7:0] rbyte;
    logic busy, rvalid, done, anack, alert_n;
    logic [7:0] rq[$];
    int n_fail = 0;
    int checks_done = 0;
    wire logic [15:0] pins = ext & ~port_oe;
    // Rising edges never coincide: even versus odd times
    always #5 i_mclk = ~i_mclk;
    always #3 i_link_clk = ~i_link_clk;
    // ----------------------------------------------------------------
    // Instances
    // ----------------------------------------------------------------
    expander_link_if link ();
    port_expander_host #(.QUARTER(4)) port_expander_host_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .link(link), .i_go(go), .i_rw(rw), .i_addr(addr), .i_len(len), .i_wdata(wdata),
        .o_busy(busy), .o_rbyte(rbyte), .o_rbyte_valid(rvalid), .o_done(done),
        .o_addr_nack(anack));
    port_expander_dev port_expander_dev_inst (.i_link_clk(i_link_clk), .i_rst(i_rst),
        .link(link), .i_port_in(pins), .o_port_out(port_out), .o_port_oe(port_oe),
        .o_alert_n(alert_n));
    expander_link_props expander_link_props_inst (.i_link_clk(i_link_clk), .i_rst(i_rst),
        .scl(link.scl), .sda(link.sda), .d_sda_oe(link.d_sda_oe));
    // Read bytes collected as the pulse stands
    always @(posedge i_mclk) begin
        if (rvalid === 1'b1) begin
            rq.push_back(rbyte);
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic xfer(input logic r, input logic [6:0] a, input logic [15:0] n,
        input logic [15:0] d);
        int k;
        go <= 1'b1;
        rw <= r;
        addr <= a;
        len <= n;
        wdata <= d;
        @(posedge i_mclk);
        go <= 1'b0;
        @(posedge i_mclk);
        check("busy", 16'h0001, busy);
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(posedge i_mclk);
            k++;
        end
        // A transfer that never ends is a failure, not a silent pass
        if (k == 5000) begin
            n_fail++;
            end_sim();
        end
        check("busy", 16'h0000, busy);
        repeat (10) @(posedge i_mclk); // Lets the device latches settle
    endtask : xfer
    task automatic pin(input logic [15:0] v);
        ext <= v;
        repeat (10) @(posedge i_mclk); // Covers the two-stage sync
    endtask : pin
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_mclk);
        check("port_out", 16'hffff, port_out);
        check("port_oe", 16'h0000, port_oe);
        check("alert_n", 16'h0001, alert_n);
        xfer(RW_WRITE, DEF_SLAVE_ADDR, 16'h0002, 16'h3c81);
        check("port_out", 16'h3c81, port_out);
        check("addr_nack", 16'h0000, anack);
        xfer(RW_WRITE, DEF_SLAVE_ADDR, 16'h0001, 16'h00f0);
        check("port_out", 16'h3cf0, port_out);
        xfer(RW_WRITE, 7'h21, 16'h0002, 16'h0000);
        check("addr_nack", 16'h0001, anack);
        check("port_out", 16'h3cf0, port_out);
        xfer(RW_WRITE, DEF_SLAVE_ADDR, 16'h0003, 16'hff0f);
        check("port_oe", 16'h00f0, port_oe);
        pin(16'ha5c3);
        check("alert_n", 16'h0000, alert_n);
        rq.delete();
        xfer(RW_READ, DEF_SLAVE_ADDR, 16'h0003, 16'h0000);
        check("count", 16'h0003, 16'(rq.size()));
        check("byte0", 16'h0003, rq[0]);
        check("byte1", 16'h00a5, rq[1]);
        check("byte2", 16'h0003, rq[2]);
        check("alert_n", 16'h0001, alert_n);
        pin(16'h5a3c);
        check("alert_n", 16'h0000, alert_n);
        pin(16'ha5c3);
        check("alert_n", 16'h0001, alert_n);
        pin(16'h5a3c);
        xfer(RW_READ, DEF_SLAVE_ADDR, 16'h0001, 16'h0000);
        check("alert_n", 16'h0000, alert_n);
        xfer(RW_READ, DEF_SLAVE_ADDR, 16'h0002, 16'h0000);
        check("alert_n", 16'h0001, alert_n);
        pin(16'ha5c3);
        xfer(RW_WRITE, DEF_SLAVE_ADDR, 16'h0002, 16'hff0f);
        check("alert_n", 16'h0001, alert_n);
        end_sim();
    end
    // Cut a hang short well past the longest sequence
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule : testbench
